// ==== verilog/icw_pkg.sv ====
// constants and types of the i2c command word and scl high count block
package icw_pkg;
  // ==================================================
  // register offsets
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_DATA_CMD = 8'h10;
  localparam logic [7:0] ADDR_SS_HCNT = 8'h14;
  localparam logic [7:0] ADDR_SS_LCNT = 8'h18;
  localparam logic [7:0] ADDR_RAW_INTR = 8'h34;
  localparam logic [7:0] ADDR_ENABLE = 8'h6c;
  localparam logic [7:0] ADDR_STATUS = 8'h70;
  // ==================================================
  // field positions
  localparam int CMD_STOP_BIT = 9;
  localparam int CMD_DIR_BIT = 8;
  localparam int TAR_COMMAND_ENABLE_A_BIT = 11;
  localparam int TAR_GC_BIT = 10;
  localparam int INTR_TX_ABORT_BIT = 6;
  localparam int EN_ENABLE_BIT = 0;
  localparam int EN_MASTER_BIT = 1;
  // ==================================================
  // codes and reset values
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [11:0] TARGET_RESET = 12'h055;
  localparam logic [1:0] ENABLE_RESET = 2'h2;
  localparam logic [15:0] SS_HCNT_RESET = 16'h0028;
  localparam logic [15:0] SS_HCNT_MIN = 16'h0006;
  localparam logic [15:0] SS_LCNT_RESET = 16'h002f;
  localparam logic [15:0] SS_LCNT_MIN = 16'h0008;
  localparam logic [15:0] IDLE_MARGIN = 16'h000a;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ==================================================
  // transmit queue
  localparam int TXQ_AW = 2;
  localparam int TXQ_DEPTH = 4;
  localparam logic [TXQ_AW:0] TXQ_FULL_CNT = 3'h4;
  // ==================================================
  // link state machine
  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_START = 3'b001,
    LK_LOW = 3'b010,
    LK_HIGH = 3'b011,
    LK_HOLD = 3'b100,
    LK_STOP_LOW = 3'b101,
    LK_STOP_HIGH = 3'b110
  } icw_lk_state_t;
endpackage

// ==== verilog/icw_sync2.sv ====
// two flip-flop synchroniser for levels and quasi-static words
`timescale 1ns/10ps
module icw_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// ==== verilog/icw_cmd_ctrl.sv ====
// i2c command word queue, standard-speed scl timing and bus engine
`timescale 1ns/10ps
// ==================================================
module icw_cmd_ctrl
  import icw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic rd_req_event,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);
  logic [1:0] crst_reg;
  logic [1:0] lrst_reg;
  logic core_rst_n;
  logic lk_rst_n;
  logic [1:0] enable_reg;
  logic run_reg;
  logic [11:0] target_reg;
  logic [15:0] hcnt_reg;
  logic [15:0] lcnt_reg;
  logic abort_reg;
  logic rd_req_seen_reg;
  logic gc_sent_reg;
  logic busy_reg;
  logic req_tgl_reg;
  logic ack_seen_reg;
  logic abort_seen_reg;
  logic cw_stop_reg;
  logic cw_dir_reg;
  logic cw_ack_reg;
  logic [7:0] cw_data_reg;
  logic [6:0] cw_addr_reg;
  logic [7:0] rx_byte_reg;
  logic rx_valid_reg;
  logic [31:0] reg_rdata_reg;
  logic [9:0] txq_mem [0:TXQ_DEPTH-1];
  logic [TXQ_AW:0] txq_wr_reg;
  logic [TXQ_AW:0] txq_rd_reg;
  logic [TXQ_AW:0] txq_cnt;
  logic [TXQ_AW-1:0] nxt_idx;
  logic [9:0] head;
  logic [9:0] next_ent;
  logic [9:0] push_word;
  logic txq_full;
  logic txq_empty;
  logic wr_tar, wr_cmd, wr_hcnt, wr_lcnt, wr_raw, wr_en, rd_cmd;
  logic cfg_ok, master_on, gc_mode, dir_bit;
  logic abort_gc, abort_rdreq, push, send, more_read;
  logic ack_edge, lk_abort_edge;
  logic [2:0] core_st;
  logic [1:0] lk_ctl;
  logic [31:0] lk_cfg;
  logic [1:0] lk_pin;
  logic lk_run, lk_req, lk_scl, lk_sda;
  logic [15:0] hcnt_l, hcnt_m1, lcnt_m1, idle_limit;
  icw_lk_state_t lk_state;
  logic [15:0] lk_cnt_reg;
  logic [15:0] idle_cnt_reg;
  logic [3:0] lk_bit_reg;
  logic [7:0] lk_shift_reg;
  logic [7:0] lk_data_reg;
  logic [7:0] lk_rx_reg;
  logic lk_addr_ph_reg, lk_stop_reg, lk_dir_reg, lk_ack_reg;
  logic lk_req_seen_reg, ack_tgl_reg, abort_tgl_reg, lk_busy_reg;
  logic scl_oe_reg, sda_oe_reg, out_low_reg;
  logic lk_pend, lk_take, tx_phase, drive_low, bus_free;

  // ==================================================
  // reset release per domain
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) crst_reg <= 2'h0;
    else crst_reg <= {crst_reg[0], 1'b1};
  end
  assign core_rst_n = crst_reg[1];

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) lrst_reg <= 2'h0;
    else lrst_reg <= {lrst_reg[0], 1'b1};
  end
  assign lk_rst_n = lrst_reg[1];

  // ==================================================
  // register decode
  assign wr_tar = reg_wr && (reg_addr == ADDR_TARGET);
  assign wr_cmd = reg_wr && (reg_addr == ADDR_DATA_CMD);
  assign wr_hcnt = reg_wr && (reg_addr == ADDR_SS_HCNT);
  assign wr_lcnt = reg_wr && (reg_addr == ADDR_SS_LCNT);
  assign wr_raw = reg_wr && (reg_addr == ADDR_RAW_INTR);
  assign wr_en = reg_wr && (reg_addr == ADDR_ENABLE);
  assign rd_cmd = reg_rd && (reg_addr == ADDR_DATA_CMD);
  assign cfg_ok = !enable_reg[EN_ENABLE_BIT];
  assign master_on = enable_reg[EN_MASTER_BIT];
  assign gc_mode = target_reg[TAR_COMMAND_ENABLE_A_BIT] && !target_reg[TAR_GC_BIT];
  assign dir_bit = reg_wdata[CMD_DIR_BIT];

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      enable_reg <= ENABLE_RESET;
      run_reg <= 1'b0;
    end else begin
      if (wr_en) enable_reg <= reg_wdata[1:0];
      run_reg <= enable_reg[EN_ENABLE_BIT] && enable_reg[EN_MASTER_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) target_reg <= TARGET_RESET;
    else if (wr_tar && cfg_ok) target_reg <= reg_wdata[11:0];
  end

  // ==================================================
  // scl count registers
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) hcnt_reg <= SS_HCNT_RESET;
    else if (wr_hcnt && cfg_ok) begin
      if (reg_wdata[15:0] < SS_HCNT_MIN) hcnt_reg <= SS_HCNT_MIN;
      else hcnt_reg <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) lcnt_reg <= SS_LCNT_RESET;
    else if (wr_lcnt && cfg_ok) begin
      if (reg_wdata[15:0] < SS_LCNT_MIN) lcnt_reg <= SS_LCNT_MIN;
      else lcnt_reg <= reg_wdata[15:0];
    end
  end

  // ==================================================
  // transmit queue
  assign abort_gc = wr_cmd && master_on && dir_bit && gc_mode && gc_sent_reg;
  assign abort_rdreq = wr_cmd && !master_on && dir_bit && rd_req_seen_reg;
  assign push = wr_cmd && !abort_gc && !abort_rdreq && !txq_full && (master_on || !dir_bit);
  assign push_word = {reg_wdata[CMD_STOP_BIT], dir_bit, dir_bit ? 8'h00 : reg_wdata[7:0]};
  assign txq_cnt = txq_wr_reg - txq_rd_reg;
  assign txq_full = txq_cnt == TXQ_FULL_CNT;
  assign txq_empty = txq_cnt == '0;
  assign nxt_idx = txq_rd_reg[TXQ_AW-1:0] + 2'h1;
  assign head = txq_mem[txq_rd_reg[TXQ_AW-1:0]];
  assign next_ent = txq_mem[nxt_idx];
  assign send = !busy_reg && !txq_empty && run_reg;
  assign more_read = (txq_cnt > 3'h1) && next_ent[CMD_DIR_BIT] && head[CMD_DIR_BIT]
    && !head[CMD_STOP_BIT];

  always_ff @(posedge core_clk) begin
    if (push) txq_mem[txq_wr_reg[TXQ_AW-1:0]] <= push_word;
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      txq_wr_reg <= '0;
      txq_rd_reg <= '0;
    end else begin
      if (push) txq_wr_reg <= txq_wr_reg + 3'h1;
      if (send) txq_rd_reg <= txq_rd_reg + 3'h1;
    end
  end

  // ==================================================
  // command hand-off to the link
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cw_stop_reg <= 1'b0;
      cw_dir_reg <= DIR_WRITE;
      cw_ack_reg <= 1'b0;
      cw_data_reg <= 8'h00;
      cw_addr_reg <= 7'h00;
      req_tgl_reg <= 1'b0;
    end else if (send) begin
      cw_stop_reg <= head[CMD_STOP_BIT];
      cw_dir_reg <= head[CMD_DIR_BIT];
      cw_data_reg <= head[7:0];
      cw_ack_reg <= more_read;
      cw_addr_reg <= gc_mode ? GC_ADDR : target_reg[6:0];
      req_tgl_reg <= !req_tgl_reg;
    end
  end

  assign ack_edge = core_st[2] != ack_seen_reg;
  assign lk_abort_edge = core_st[1] != abort_seen_reg;

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      busy_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      abort_seen_reg <= 1'b0;
    end else begin
      ack_seen_reg <= core_st[2];
      abort_seen_reg <= core_st[1];
      if (send) busy_reg <= 1'b1;
      else if (ack_edge) busy_reg <= 1'b0;
    end
  end

  // ==================================================
  // abort sources and status flags
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) gc_sent_reg <= 1'b0;
    else if (!run_reg) gc_sent_reg <= 1'b0;
    else if (send && gc_mode && !head[CMD_DIR_BIT]) gc_sent_reg <= 1'b1;
    else if (ack_edge && cw_stop_reg) gc_sent_reg <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rd_req_seen_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      rd_req_seen_reg <= rd_req_event || (rd_req_seen_reg && !(push && !master_on));
      abort_reg <= abort_gc || abort_rdreq || lk_abort_edge
        || (abort_reg && !(wr_raw && reg_wdata[INTR_TX_ABORT_BIT]));
    end
  end

  // ==================================================
  // receive byte and read port
  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rx_byte_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      if (ack_edge && cw_dir_reg) rx_byte_reg <= lk_rx_reg;
      rx_valid_reg <= (ack_edge && cw_dir_reg) || (rx_valid_reg && !rd_cmd);
    end
  end

  always_ff @(posedge core_clk or negedge core_rst_n) begin
    if (!core_rst_n) reg_rdata_reg <= 32'h0;
    else if (reg_rd) begin
      case (reg_addr)
        ADDR_DATA_CMD: reg_rdata_reg <= {24'h0, rx_byte_reg};
        ADDR_TARGET: reg_rdata_reg <= {20'h0, target_reg};
        ADDR_SS_HCNT: reg_rdata_reg <= {16'h0, hcnt_reg};
        ADDR_SS_LCNT: reg_rdata_reg <= {16'h0, lcnt_reg};
        ADDR_RAW_INTR: reg_rdata_reg <= 32'(abort_reg) << INTR_TX_ABORT_BIT;
        ADDR_ENABLE: reg_rdata_reg <= {30'h0, enable_reg};
        ADDR_STATUS: reg_rdata_reg <= {28'h0, rx_valid_reg, txq_empty, !txq_full, core_st[0]};
        default: reg_rdata_reg <= 32'h0;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_reg;

  // ==================================================
  // domain crossings
  icw_sync2 #(.WIDTH(3)) u_core_st (
    .clk(core_clk),
    .rst_n(core_rst_n),
    .d({ack_tgl_reg, abort_tgl_reg, lk_busy_reg}),
    .q(core_st)
  );
  icw_sync2 #(.WIDTH(2)) u_lk_ctl (
    .clk(link_clk),
    .rst_n(lk_rst_n),
    .d({run_reg, req_tgl_reg}),
    .q(lk_ctl)
  );
  icw_sync2 #(.WIDTH(32)) u_lk_cfg (
    .clk(link_clk),
    .rst_n(lk_rst_n),
    .d({hcnt_reg, lcnt_reg}),
    .q(lk_cfg)
  );
  icw_sync2 #(.WIDTH(2)) u_lk_pin (
    .clk(link_clk),
    .rst_n(lk_rst_n),
    .d({scl_in, sda_in}),
    .q(lk_pin)
  );
  assign lk_run = lk_ctl[1];
  assign lk_req = lk_ctl[0];
  assign lk_scl = lk_pin[1];
  assign lk_sda = lk_pin[0];
  assign hcnt_l = lk_cfg[31:16];
  assign hcnt_m1 = hcnt_l - 16'h1;
  assign lcnt_m1 = lk_cfg[15:0] - 16'h1;

  // ==================================================
  // link engine
  assign lk_pend = lk_req != lk_req_seen_reg;
  assign lk_take = lk_run && lk_pend;
  assign tx_phase = lk_addr_ph_reg || (lk_dir_reg == DIR_WRITE);
  assign drive_low = (lk_bit_reg != 4'h0) ? (tx_phase && !lk_shift_reg[7])
    : (!tx_phase && lk_ack_reg);
  assign idle_limit = hcnt_l + IDLE_MARGIN;
  assign bus_free = idle_cnt_reg >= idle_limit;

  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) idle_cnt_reg <= 16'h0;
    else if (lk_scl && lk_sda && !scl_oe_reg && !sda_oe_reg) begin
      if (idle_cnt_reg != 16'hffff) idle_cnt_reg <= idle_cnt_reg + 16'h1;
    end else idle_cnt_reg <= 16'h0;
  end

  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_stop_reg <= 1'b0;
      lk_dir_reg <= DIR_WRITE;
      lk_ack_reg <= 1'b0;
      lk_data_reg <= 8'h00;
      lk_req_seen_reg <= 1'b0;
    end else if (lk_take && (lk_state == LK_HOLD || (lk_state == LK_IDLE && bus_free))) begin
      lk_stop_reg <= cw_stop_reg;
      lk_dir_reg <= cw_dir_reg;
      lk_ack_reg <= cw_ack_reg;
      lk_data_reg <= cw_data_reg;
      lk_req_seen_reg <= lk_req;
    end
  end

  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_state <= LK_IDLE;
      lk_cnt_reg <= 16'h0;
      lk_bit_reg <= 4'h0;
      lk_shift_reg <= 8'h00;
      lk_addr_ph_reg <= 1'b0;
      lk_rx_reg <= 8'h00;
      ack_tgl_reg <= 1'b0;
      abort_tgl_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      case (lk_state)
        LK_IDLE: begin
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
          if (lk_take && bus_free) begin
            lk_shift_reg <= {cw_addr_reg, cw_dir_reg};
            lk_addr_ph_reg <= 1'b1;
            lk_bit_reg <= BITS_PER_BYTE;
            sda_oe_reg <= 1'b1;
            lk_cnt_reg <= hcnt_m1;
            lk_state <= LK_START;
          end
        end
        LK_START: begin
          if (lk_cnt_reg != 16'h0) lk_cnt_reg <= lk_cnt_reg - 16'h1;
          else begin
            scl_oe_reg <= 1'b1;
            lk_cnt_reg <= lcnt_m1;
            lk_state <= LK_LOW;
          end
        end
        LK_LOW: begin
          sda_oe_reg <= drive_low;
          if (lk_cnt_reg != 16'h0) lk_cnt_reg <= lk_cnt_reg - 16'h1;
          else begin
            scl_oe_reg <= 1'b0;
            lk_cnt_reg <= hcnt_m1;
            lk_state <= LK_HIGH;
          end
        end
        LK_HIGH: begin
          if (lk_cnt_reg != 16'h0) lk_cnt_reg <= lk_cnt_reg - 16'h1;
          else if (lk_bit_reg != 4'h0 && tx_phase && !sda_oe_reg && !lk_sda) begin
            abort_tgl_reg <= !abort_tgl_reg;
            ack_tgl_reg <= !ack_tgl_reg;
            lk_state <= LK_IDLE;
          end else if (lk_bit_reg != 4'h0) begin
            lk_shift_reg <= {lk_shift_reg[6:0], lk_sda};
            lk_bit_reg <= lk_bit_reg - 4'h1;
            scl_oe_reg <= 1'b1;
            lk_cnt_reg <= lcnt_m1;
            lk_state <= LK_LOW;
          end else if (tx_phase && lk_sda) begin
            abort_tgl_reg <= !abort_tgl_reg;
            ack_tgl_reg <= !ack_tgl_reg;
            scl_oe_reg <= 1'b1;
            lk_cnt_reg <= lcnt_m1;
            lk_state <= LK_STOP_LOW;
          end else if (lk_addr_ph_reg) begin
            lk_addr_ph_reg <= 1'b0;
            lk_shift_reg <= lk_data_reg;
            lk_bit_reg <= BITS_PER_BYTE;
            scl_oe_reg <= 1'b1;
            lk_cnt_reg <= lcnt_m1;
            lk_state <= LK_LOW;
          end else begin
            lk_rx_reg <= lk_shift_reg;
            ack_tgl_reg <= !ack_tgl_reg;
            scl_oe_reg <= 1'b1;
            lk_cnt_reg <= lcnt_m1;
            lk_state <= lk_stop_reg ? LK_STOP_LOW : LK_HOLD;
          end
        end
        LK_HOLD: begin
          scl_oe_reg <= 1'b1;
          sda_oe_reg <= 1'b0;
          if (lk_take) begin
            lk_shift_reg <= cw_data_reg;
            lk_bit_reg <= BITS_PER_BYTE;
            lk_cnt_reg <= lcnt_m1;
            lk_state <= LK_LOW;
          end else if (!lk_run) begin
            lk_cnt_reg <= lcnt_m1;
            lk_state <= LK_STOP_LOW;
          end
        end
        LK_STOP_LOW: begin
          sda_oe_reg <= 1'b1;
          if (lk_cnt_reg != 16'h0) lk_cnt_reg <= lk_cnt_reg - 16'h1;
          else begin
            scl_oe_reg <= 1'b0;
            lk_cnt_reg <= hcnt_m1;
            lk_state <= LK_STOP_HIGH;
          end
        end
        LK_STOP_HIGH: begin
          if (lk_cnt_reg != 16'h0) lk_cnt_reg <= lk_cnt_reg - 16'h1;
          else begin
            sda_oe_reg <= 1'b0;
            lk_state <= LK_IDLE;
          end
        end
        default: lk_state <= LK_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_busy_reg <= 1'b0;
      out_low_reg <= 1'b0;
    end else begin
      lk_busy_reg <= lk_state != LK_IDLE;
      out_low_reg <= 1'b0;
    end
  end
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign scl_out = out_low_reg;
  assign sda_out = out_low_reg;

  // ==================================================
  // checks
  sequence s_push;
    push && !send;
  endsequence
  sequence s_byte_end;
    lk_state == LK_HIGH && lk_cnt_reg == 16'h0 && lk_bit_reg == 4'h0 && !lk_addr_ph_reg
      && !(tx_phase && lk_sda);
  endsequence
  property p_hcnt_clamp;
    @(posedge core_clk) disable iff (!core_rst_n)
    (wr_hcnt && cfg_ok && reg_wdata[15:0] < SS_HCNT_MIN) |=> hcnt_reg == SS_HCNT_MIN;
  endproperty
  a_hcnt_clamp: assert property (p_hcnt_clamp) else $error("high count not clamped");
  property p_hcnt_locked;
    @(posedge core_clk) disable iff (!core_rst_n)
    (wr_hcnt && !cfg_ok) |=> $stable(hcnt_reg);
  endproperty
  a_hcnt_locked: assert property (p_hcnt_locked) else $error("high count written while on");
  property p_hcnt_store;
    @(posedge core_clk) disable iff (!core_rst_n)
    (wr_hcnt && cfg_ok && reg_wdata[15:0] >= SS_HCNT_MIN) |=> hcnt_reg == $past(reg_wdata[15:0]);
  endproperty
  a_hcnt_store: assert property (p_hcnt_store) else $error("high count not stored");
  property p_gc_abort;
    @(posedge core_clk) disable iff (!core_rst_n)
    (wr_cmd && master_on && dir_bit && gc_mode && gc_sent_reg) |=> abort_reg && $stable(txq_wr_reg);
  endproperty
  a_gc_abort: assert property (p_gc_abort) else $error("read after call not aborted");
  property p_rdreq_abort;
    @(posedge core_clk) disable iff (!core_rst_n)
    (wr_cmd && !master_on && dir_bit && rd_req_seen_reg) |=> abort_reg;
  endproperty
  a_rdreq_abort: assert property (p_rdreq_abort) else $error("read request abort missing");
  property p_push;
    @(posedge core_clk) disable iff (!core_rst_n)
    s_push |=> txq_cnt == $past(txq_cnt) + 3'h1;
  endproperty
  a_push: assert property (p_push) else $error("command not queued");
  property p_pop;
    @(posedge core_clk) disable iff (!core_rst_n)
    (rd_cmd && !(ack_edge && cw_dir_reg)) |=> !rx_valid_reg
      && reg_rdata_reg[7:0] == $past(rx_byte_reg);
  endproperty
  a_pop: assert property (p_pop) else $error("received byte not returned");
  property p_hold;
    @(posedge link_clk) disable iff (!lk_rst_n)
    (lk_state == LK_HOLD && lk_run && !lk_pend) |=> lk_state == LK_HOLD && scl_oe_reg;
  endproperty
  a_hold: assert property (p_hold) else $error("scl not held while stalled");
  property p_high_count;
    @(posedge link_clk) disable iff (!lk_rst_n)
    (lk_state == LK_HIGH && lk_cnt_reg != 16'h0) |=> lk_state == LK_HIGH && !scl_oe_reg
      && lk_cnt_reg == $past(lk_cnt_reg) - 16'h1;
  endproperty
  a_high_count: assert property (p_high_count) else $error("scl high count broken");
  property p_byte_end;
    @(posedge link_clk) disable iff (!lk_rst_n)
    s_byte_end |=> ($past(lk_stop_reg) ? lk_state == LK_STOP_LOW : lk_state == LK_HOLD);
  endproperty
  a_byte_end: assert property (p_byte_end) else $error("wrong step after byte");
  property p_idle_wait;
    @(posedge link_clk) disable iff (!lk_rst_n)
    (lk_state == LK_IDLE && !bus_free) |=> lk_state == LK_IDLE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("start before bus idle");
endmodule

// ==== tb/icw_target_model.sv ====
// i2c target model: acknowledges written bytes and returns a fixed byte on reads
`timescale 1ns/10ps
module icw_target_model #(
  parameter logic [7:0] TX_BYTE = 8'hc3
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  // ==================================================
  // bit counter and direction, cleared by a start
  int n = 0;
  logic rd = 1'b0;
  initial sda_pull = 1'b0;
  always @(negedge sda) if (scl) begin
    n = 0;
    rd = 1'b0;
  end
  always @(posedge scl) begin
    n = n + 1;
    if (n == 8) rd = sda;
  end
  // bit 7 of the byte must be 1 so that a nack frees sda before the stop
  always @(negedge scl) begin
    if (rd && n >= 9) sda_pull <= (n % 9 != 8) && !TX_BYTE[7 - n % 9];
    else sda_pull <= (n % 9 == 8);
  end
endmodule

// ==== tb/icw_cmd_ctrl_bench.sv ====
// self-checking bench of the command word and scl high count block
`timescale 1ns/10ps
module icw_cmd_ctrl_bench;
  import icw_pkg::*;
  // ==================================================
  // signals
  logic core_clk = 0, link_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_req_event = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, v;
  logic scl_out, scl_oe, sda_out, sda_oe, tpull;
  logic [8:0] sh, last;
  wire scl, sda;
  int err_count = 0, num_checks = 0, seed = 40, starts = 0, stops = 0, s, t;
  int hi_ns = 0, gap_ns = 0;
  realtime t_rise = 0, t_stop = 0;
  localparam logic [7:0] TX_BYTE = 8'hc3;
  assign scl = scl_oe !== 1'b1;
  assign sda = !(sda_oe === 1'b1 || tpull === 1'b1);
  initial forever #4 core_clk = ~core_clk;
  initial begin
    #13;
    forever #32 link_clk = ~link_clk;
  end
  icw_cmd_ctrl i_dut(.core_clk, .rst_b, .link_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .rd_req_event, .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe, .sda_out, .sda_oe);
  icw_target_model #(.TX_BYTE(TX_BYTE)) i_tgt(.scl(scl), .sda(sda), .sda_pull(tpull));
  // ==================================================
  // bus monitor
  always @(posedge scl) sh <= {sh[7:0], sda};
  always @(posedge scl) t_rise = $realtime;
  always @(negedge scl) hi_ns = int'($realtime - t_rise);
  always @(negedge sda) if (scl) begin
    starts++;
    gap_ns = int'($realtime - t_stop);
  end
  always @(posedge sda) if (scl) begin
    stops++;
    last = sh;
    t_stop = $realtime;
  end
  // ==================================================
  // tasks
  task wr(input logic [7:0] a, input logic [31:0] x);
    @(negedge core_clk) reg_addr = a;
    reg_wdata = x;
    reg_wr = 1;
    @(negedge core_clk) reg_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge core_clk) reg_addr = a;
    reg_rd = 1;
    @(negedge core_clk) reg_rd = 0;
    @(negedge core_clk) d = reg_rdata;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wait_stops(input int n);
    for (int i = 0; i < 40000 && stops < n; i++) @(negedge core_clk);
    chk("stop_seen", 32'(stops >= n), 32'h1);
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] exp_h(input logic [15:0] x);
    return (x < SS_HCNT_MIN) ? {16'h0, SS_HCNT_MIN} : {16'h0, x};
  endfunction
  // ==================================================
  // main sequence
  initial begin
    repeat (4) @(negedge link_clk);
    rst_b = 1;
    repeat (4) @(negedge core_clk);
    rd(ADDR_SS_HCNT);
    chk("hcnt_reset", d, 32'h0000_0028);
    for (int i = 0; i < 12; i++) begin
      v = (i < 8) ? i : (i == 8) ? 32'hfff5 : ($random(seed) & 32'h7fff);
      wr(ADDR_SS_HCNT, v);
      rd(ADDR_SS_HCNT);
      chk("hcnt", d, exp_h(v[15:0]));
    end
    wr(ADDR_SS_HCNT, 32'h8);
    wr(ADDR_ENABLE, 32'h3);
    wr(ADDR_SS_HCNT, 32'h40);
    rd(ADDR_SS_HCNT);
    chk("hcnt_locked", d, 32'h8);
    s = stops;
    t = starts;
    wr(ADDR_DATA_CMD, 32'h2a5);
    wr(ADDR_DATA_CMD, 32'h23c);
    wait_stops(s + 2);
    chk("starts", 32'(starts - t), 32'h2);
    chk("last_byte", 32'(last), 32'({7'h3c, 2'b00}));
    chk("idle_gap", 32'(gap_ns >= (8 + 10) * 64), 32'h1);
    s = stops;
    t = starts;
    wr(ADDR_DATA_CMD, 32'h011);
    wr(ADDR_DATA_CMD, 32'h022);
    repeat (20000) @(negedge core_clk);
    chk("stall_scl", 32'(scl), 32'h0);
    chk("no_stop", 32'(stops - s), 32'h0);
    chk("scl_high", hi_ns, 32'(8 * 64));
    chk("pins_low", {30'h0, scl_out, sda_out}, 32'h0);
    wr(ADDR_DATA_CMD, 32'h233);
    wait_stops(s + 1);
    chk("one_start", 32'(starts - t), 32'h1);
    wr(ADDR_ENABLE, 32'h2);
    wr(ADDR_DATA_CMD, 32'h1a5);
    wr(ADDR_DATA_CMD, 32'h300);
    s = stops;
    wr(ADDR_ENABLE, 32'h3);
    wait_stops(s + 1);
    chk("read_nack", 32'(last), 32'({TX_BYTE[6:0], 2'b10}));
    rd(ADDR_DATA_CMD);
    chk("rx_byte", d, {24'h0, TX_BYTE});
    wr(ADDR_ENABLE, 32'h2);
    wr(ADDR_TARGET, 32'h855);
    wr(ADDR_DATA_CMD, 32'h0aa);
    wr(ADDR_ENABLE, 32'h3);
    repeat (8) @(negedge core_clk);
    wr(ADDR_DATA_CMD, 32'h100);
    rd(ADDR_RAW_INTR);
    chk("gc_abort", 32'(d[6]), 32'h1);
    wr(ADDR_RAW_INTR, 32'h40);
    s = stops;
    wr(ADDR_DATA_CMD, 32'h200);
    wait_stops(s + 1);
    chk("gc_byte", 32'(last), 32'h0);
    wr(ADDR_ENABLE, 32'h0);
    @(negedge core_clk) rd_req_event = 1;
    @(negedge core_clk) rd_req_event = 0;
    wr(ADDR_DATA_CMD, 32'h100);
    rd(ADDR_RAW_INTR);
    chk("abort", 32'(d[6]), 32'h1);
    wr(ADDR_RAW_INTR, 32'h40);
    rd(ADDR_RAW_INTR);
    chk("abort_clear", 32'(d[6]), 32'h0);
    wr(ADDR_DATA_CMD, 32'h05a);
    rd(ADDR_STATUS);
    chk("tgt_queued", 32'(d[2:1]), 32'h1);
    final_report;
  end
  initial begin
    #750000;
    err_count++;
    final_report;
  end
endmodule
